// ---- core/ctf_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// [R1] Bit split into sync, prop, two phases.
// [R2] Late edge lengthens phase one, RESYNC_JUMP_WIDTH max.
// [R3] Early edge shortens phase two, RESYNC_JUMP_WIDTH max.
// [R4] Bit rate: clock/2/core div/prescaler/quanta.
// [R5] Core clock divide 1,2,4,8,16 selectable.
// [R6] Prescaler divides by field plus one.
// [R7] Global mask 0-13, A 14, B 15.
// [R8] Mask covers 11 or 29 bits per format.
// [R9] Lower slot wins duplicate identifiers.
// [R10] Two-slot pair takes all unstored messages.
// [R11] Standard identifier latched, decoded for lookup.
// [R12] Pair accepts both frame types in mode.
// [R13] Pair alternates; remote flag shows type.
// [R14] Software changes mode only in init.
// [R15] Software configures pair identically, receive only.
// [R16] Pair has no overwrite protection.
// [R17] Force return clears counters and bus off.
// [R18] Time stamp read returns live count.
// [R19] Stamp ticks per bit divided 1,2,4,8.
// [R20] Reception captures stamp into slot.
// [R21] Listen-only drives nothing onto bus.
// [R22] Software requests no transmit while listening.
// [R23] 128 recessive runs end bus off.
// [R24] Forced return waits 11 recessive; self-clears.
// [R25] Stamp clear zeroes counter, self-clears.
// [R26] Sample at phase boundary; stamp wraps.
module ctf_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic can_rx,
  output logic can_tx,
  input wire logic pe_tx_bit,
  input wire logic rx_frame_done,
  input wire logic [ctf_pkg::ID_W-1:0] rx_frame_id,
  input wire logic rx_frame_ext,
  input wire logic rx_frame_remote,
  input wire logic err_rx_inc,
  input wire logic err_tx_inc,
  input wire logic err_dec,
  output logic store_valid,
  output logic [3:0] store_slot,
  output logic store_remote,
  output logic [ctf_pkg::TS_W-1:0] store_ts,
  output logic comm_ready,
  output logic busoff_flag
);
  import ctf_pkg::*;

  logic [31:0] hrdata_q, rdata_d;
  logic hreadyout_q, hresp_q, rd_take, wr_pend_q;
  logic [7:0] a_off, wr_off_q;
  logic [2:0] clk_sel_q, ts_div_q;
  logic [31:0] bit_cfg_q;
  logic two_slot_q, listen_only_q, force_q, ts_clr_q;
  logic [ID_W-1:0] gmask_q, lmask_a_q, lmask_b_q;
  logic [SLOT_COUNT-1:0] id_fmt_q, rx_en_q, rsel_q, rflag_q, newd_q, hit;
  logic [ID_W-1:0] slot_id_q [SLOT_COUNT];
  logic [TS_W-1:0] slot_ts_q [SLOT_COUNT];
  logic [15:0] fs_q;
  logic any_hit, accept, alt_q, basic_pick;
  logic [3:0] first_slot, target;
  logic store_valid_q, store_remote_q, can_tx_q;
  logic [3:0] store_slot_q;
  logic [TS_W-1:0] store_ts_q, ts_cnt_q;
  logic [2:0] ts_pre_q;
  logic sample_pulse, sample_bit, bit_start, run_done;
  logic [3:0] rec_run_q;
  logic [6:0] runs_q;
  logic busoff_q, comm_ready_q;
  logic [7:0] rx_err_q;
  logic [8:0] tx_err_q;

  ctf_bit_timing u_timing (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_sel(clk_sel_q),
    .prescale(bit_cfg_q[BC_PRESC_LSB +: 4]),
    .prop_len(bit_cfg_q[BC_PROP_LSB +: 3]),
    .ps1_len(bit_cfg_q[BC_PS1_LSB +: 3]),
    .ps2_len(bit_cfg_q[BC_PS2_LSB +: 3]),
    .resync_jump_width(bit_cfg_q[BC_SJW_LSB +: 2]),
    .rx_in(can_rx),
    .sample_pulse(sample_pulse),
    .sample_bit(sample_bit),
    .bit_start(bit_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave. Zero wait states; read data is fetched at the address phase, so a
  // read right behind a write to the same register returns the older value.
  assign a_off = haddr[7:0];
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_off_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_pend_q <= hsel && htrans[1] && hready && hwrite;
      wr_off_q <= a_off;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      if (rd_take) begin
        hrdata_q <= rdata_d;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (a_off[7:6])
      RGN_SLOT_ID: rdata_d = {3'h0, slot_id_q[a_off[5:2]]};
      RGN_SLOT_CTL: rdata_d = {28'h0, newd_q[a_off[5:2]], rflag_q[a_off[5:2]], rsel_q[a_off[5:2]],
                               rx_en_q[a_off[5:2]]};
      RGN_SLOT_TS: rdata_d = {16'h0, slot_ts_q[a_off[5:2]]};
      default: begin
        case (a_off)
          OFF_CLK_SEL: rdata_d = {29'h0, clk_sel_q};
          OFF_BIT_CFG: rdata_d = bit_cfg_q;
          OFF_CTRL: rdata_d = {26'h0, listen_only_q, ts_div_q[1:0], ts_clr_q, force_q, two_slot_q};
          OFF_STATUS: rdata_d = {29'h0, alt_q, comm_ready_q, busoff_q};
          OFF_ERR_CNT: rdata_d = {7'h0, tx_err_q, 8'h0, rx_err_q};
          OFF_TS_VALUE: rdata_d = {16'h0, ts_cnt_q}; // [R18]
          OFF_GMASK: rdata_d = {3'h0, gmask_q};
          OFF_LMASK_A: rdata_d = {3'h0, lmask_a_q};
          OFF_LMASK_B: rdata_d = {3'h0, lmask_b_q};
          OFF_ID_FMT: rdata_d = {16'h0, id_fmt_q};
          OFF_FILT_SUP: rdata_d = {16'h0, fs_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel_q <= CLK_SEL_RST;
      bit_cfg_q <= BIT_CFG_RST;
      two_slot_q <= 1'b0;
      listen_only_q <= 1'b0;
      ts_div_q <= 3'h0;
      gmask_q <= MASK_RST;
      lmask_a_q <= MASK_RST;
      lmask_b_q <= MASK_RST;
      id_fmt_q <= '0;
    end else if (wr_pend_q) begin
      case (wr_off_q)
        OFF_CLK_SEL: clk_sel_q <= hwdata[2:0]; // [R5]
        OFF_BIT_CFG: bit_cfg_q <= {14'h0, hwdata[17:0]};
        OFF_CTRL: begin
          two_slot_q <= hwdata[CT_TWO_SLOT];
          ts_div_q <= {1'b0, hwdata[CT_TS_DIV_LSB +: 2]};
          listen_only_q <= hwdata[CT_LISTEN];
        end
        OFF_GMASK: gmask_q <= hwdata[ID_W-1:0];
        OFF_LMASK_A: lmask_a_q <= hwdata[ID_W-1:0];
        OFF_LMASK_B: lmask_b_q <= hwdata[ID_W-1:0];
        OFF_ID_FMT: id_fmt_q <= hwdata[SLOT_COUNT-1:0];
        default: ;
      endcase
    end
  end

  // Both command bits read as one for exactly one cycle, then fall back.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      force_q <= 1'b0;
      ts_clr_q <= 1'b0;
    end else begin
      force_q <= wr_pend_q && wr_off_q == OFF_CTRL && hwdata[CT_FORCE_RET]; // [R24]
      ts_clr_q <= wr_pend_q && wr_off_q == OFF_CTRL && hwdata[CT_TS_CLR]; // [R25]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acceptance filter. A mask bit of one means that identifier bit is compared.
  generate
    for (genvar i = 0; i < SLOT_COUNT; i++) begin : g_slot
      logic [ID_W-1:0] mask, wmask;
      logic type_ok;
      assign mask = (i < GMASK_SLOTS) ? gmask_q : (i == SLOT_LMASK_A) ? lmask_a_q : lmask_b_q; // [R7]
      assign wmask = id_fmt_q[i] ? {ID_W{1'b1}} : {{(ID_W-STD_ID_W){1'b0}}, {STD_ID_W{1'b1}}}; // [R8]
      assign type_ok = (two_slot_q && i >= GMASK_SLOTS) || (rsel_q[i] == rx_frame_remote); // [R12]
      assign hit[i] = rx_en_q[i] && (id_fmt_q[i] == rx_frame_ext) && type_ok &&
                      (((rx_frame_id ^ slot_id_q[i]) & mask & wmask) == '0);

      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          slot_id_q[i] <= '0;
          rx_en_q[i] <= 1'b0;
          rsel_q[i] <= 1'b0;
          rflag_q[i] <= 1'b0;
          newd_q[i] <= 1'b0;
          slot_ts_q[i] <= '0;
        end else begin
          if (wr_pend_q && wr_off_q[7:6] == RGN_SLOT_ID && wr_off_q[5:2] == 4'(i)) begin
            slot_id_q[i] <= hwdata[ID_W-1:0];
          end
          if (wr_pend_q && wr_off_q[7:6] == RGN_SLOT_CTL && wr_off_q[5:2] == 4'(i)) begin
            rx_en_q[i] <= hwdata[SC_RX_EN];
            rsel_q[i] <= hwdata[SC_REMOTE_SEL];
            newd_q[i] <= newd_q[i] & hwdata[SC_NEW_DATA];
          end
          // A store overrides a same-cycle write to the new-data flag and ignores unread data.
          if (accept && target == 4'(i)) begin
            rflag_q[i] <= rx_frame_remote; // [R13]
            newd_q[i] <= 1'b1; // [R16]
            slot_ts_q[i] <= ts_cnt_q; // [R20]
          end
        end
      end
    end
  endgenerate

  always_comb begin
    any_hit = 1'b0;
    first_slot = 4'h0;
    for (int k = SLOT_COUNT - 1; k >= 0; k--) begin
      if (hit[k]) begin
        any_hit = 1'b1;
        first_slot = 4'(k); // [R9]
      end
    end
    basic_pick = two_slot_q && first_slot >= 4'(GMASK_SLOTS);
    target = basic_pick ? (alt_q ? 4'(SLOT_LMASK_B) : 4'(SLOT_LMASK_A)) : first_slot; // [R10] [R13]
    accept = rx_frame_done && comm_ready_q && any_hit;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      store_valid_q <= 1'b0;
      store_slot_q <= 4'h0;
      store_remote_q <= 1'b0;
      store_ts_q <= '0;
      alt_q <= 1'b0;
      fs_q <= 16'h0000;
    end else begin
      store_valid_q <= accept;
      if (accept) begin
        store_slot_q <= target;
        store_remote_q <= rx_frame_remote;
        store_ts_q <= ts_cnt_q; // [R20]
      end
      if (accept && basic_pick) begin
        alt_q <= !alt_q; // [R13]
      end
      if (rx_frame_done && !rx_frame_ext) begin
        fs_q <= {rx_frame_id[10:3], 8'(8'h01 << rx_frame_id[2:0])}; // [R11]
      end
    end
  end

  assign store_valid = store_valid_q;
  assign store_slot = store_slot_q;
  assign store_remote = store_remote_q;
  assign store_ts = store_ts_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fault confinement: error counters, bus off and the recessive-run recovery.
  assign run_done = sample_pulse && sample_bit && rec_run_q == RECESSIVE_RUN - 4'h1;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rec_run_q <= 4'h0;
    end else if (force_q && busoff_q) begin
      // A forced return must see a fresh run, not one begun while still bus off.
      rec_run_q <= 4'h0; // [R24]
    end else if (sample_pulse) begin
      rec_run_q <= (!sample_bit || run_done) ? 4'h0 : rec_run_q + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busoff_q <= 1'b0;
      comm_ready_q <= 1'b0;
      rx_err_q <= 8'h00;
      tx_err_q <= 9'h000;
      runs_q <= 7'h00;
    end else if (force_q && busoff_q) begin
      busoff_q <= 1'b0; // [R17]
      rx_err_q <= 8'h00;
      tx_err_q <= 9'h000;
      runs_q <= 7'h00;
      comm_ready_q <= 1'b0; // [R24]
    end else if (busoff_q) begin
      if (run_done) begin
        if (runs_q == 7'(BUSOFF_RUNS - 1)) begin
          busoff_q <= 1'b0; // [R23]
          comm_ready_q <= 1'b1;
          rx_err_q <= 8'h00;
          tx_err_q <= 9'h000;
          runs_q <= 7'h00;
        end else begin
          runs_q <= runs_q + 7'h01;
        end
      end
    end else begin
      if (!comm_ready_q && run_done) begin
        comm_ready_q <= 1'b1; // [R24]
      end
      if (err_rx_inc && rx_err_q != 8'hFF) begin
        rx_err_q <= rx_err_q + 8'h01;
      end else if (err_dec && rx_err_q != 8'h00) begin
        rx_err_q <= rx_err_q - 8'h01;
      end
      if (err_tx_inc) begin
        if (tx_err_q >= TX_BUSOFF_LIMIT - TX_ERR_STEP) begin
          tx_err_q <= TX_BUSOFF_LIMIT;
          busoff_q <= 1'b1;
          comm_ready_q <= 1'b0;
        end else begin
          tx_err_q <= tx_err_q + TX_ERR_STEP;
        end
      end else if (err_dec && tx_err_q != 9'h000) begin
        tx_err_q <= tx_err_q - 9'h001;
      end
    end
  end

  assign comm_ready = comm_ready_q;
  assign busoff_flag = busoff_q;

  ////////////////////////////////////////////////////////////////////////////
  // Time stamp counter, advancing once per prescaled bit time.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ts_pre_q <= 3'h0;
      ts_cnt_q <= '0;
    end else if (ts_clr_q) begin
      ts_pre_q <= 3'h0; // [R25]
      ts_cnt_q <= '0;
    end else if (bit_start) begin
      if (ts_pre_q >= 3'((4'h1 << ts_div_q) - 4'h1)) begin
        ts_pre_q <= 3'h0; // [R19]
        ts_cnt_q <= ts_cnt_q + 16'h0001; // [R26]
      end else begin
        ts_pre_q <= ts_pre_q + 3'h1;
      end
    end
  end

  // Listen-only holds the line recessive, which also suppresses error flags and acks.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      can_tx_q <= 1'b1;
    end else begin
      can_tx_q <= listen_only_q ? 1'b1 : pe_tx_bit; // [R21]
    end
  end

  assign can_tx = can_tx_q;

  ////////////////////////////////////////////////////////////////////////////
  logic last_basic_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      last_basic_q <= 1'b1;
    end else if (store_valid_q && store_slot_q[3:1] == 3'h7 && two_slot_q) begin
      last_basic_q <= store_slot_q[0];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  tx_silent_a: assert property (listen_only_q |=> can_tx_q) else $error("listen-only drove the bus"); // [R21]
  force_clear_a: assert property (force_q && busoff_q |=> !busoff_q && tx_err_q == 9'h000 && rx_err_q == 8'h00) // [R17]
    else $error("forced return did not clear state");
  force_wait_a: assert property (force_q && busoff_q |=> !comm_ready_q && !force_q) // [R24]
    else $error("forced return resumed early or stuck");
  ts_clear_a: assert property (ts_clr_q |=> ts_cnt_q == 16'h0000 && !ts_clr_q) else $error("stamp clear failed"); // [R25]
  store_follow_a: assert property (accept |=> store_valid_q && store_slot_q == $past(target)) // [R9]
    else $error("accepted frame not stored");
  low_slot_a: assert property (accept && hit[0] |=> store_slot_q == 4'h0) else $error("slot priority wrong"); // [R9]
  alternate_a: assert property (store_valid_q && two_slot_q && store_slot_q[3:1] == 3'h7 // [R13]
    |-> store_slot_q[0] != last_basic_q) else $error("two-slot pair did not alternate");
  ts_capture_a: assert property (accept |=> store_ts_q == $past(ts_cnt_q)) else $error("stamp not captured"); // [R20]
  recover_a: assert property (busoff_q && run_done && runs_q == 7'h7F && !force_q // [R23]
    |=> !busoff_q && comm_ready_q) else $error("bus off recovery missed");
  no_busoff_rx_a: assert property (busoff_q |-> ##1 !store_valid_q) else $error("stored while bus off"); // [R23]

  basic_store_c: cover property (store_valid_q && two_slot_q && store_slot_q == 4'hF);
  force_ret_c: cover property (force_q && busoff_q);
  recover_c: cover property (busoff_q ##1 !busoff_q && comm_ready_q);
  ts_clear_c: cover property (ts_clr_q);
endmodule // ctf_top

// ---- pkg/ctf_pkg.sv ----
package ctf_pkg;
  localparam int SLOT_COUNT = 16;
  localparam int GMASK_SLOTS = 14;
  localparam int SLOT_LMASK_A = 14;
  localparam int SLOT_LMASK_B = 15;
  localparam int ID_W = 29;
  localparam int STD_ID_W = 11;
  localparam int TS_W = 16;

  localparam logic [7:0] OFF_CLK_SEL = 8'h00;
  localparam logic [7:0] OFF_BIT_CFG = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_ERR_CNT = 8'h10;
  localparam logic [7:0] OFF_TS_VALUE = 8'h14;
  localparam logic [7:0] OFF_GMASK = 8'h18;
  localparam logic [7:0] OFF_LMASK_A = 8'h1C;
  localparam logic [7:0] OFF_LMASK_B = 8'h20;
  localparam logic [7:0] OFF_ID_FMT = 8'h24;
  localparam logic [7:0] OFF_FILT_SUP = 8'h28;
  localparam logic [1:0] RGN_SLOT_ID = 2'h1;
  localparam logic [1:0] RGN_SLOT_CTL = 2'h2;
  localparam logic [1:0] RGN_SLOT_TS = 2'h3;

  localparam int BC_PRESC_LSB = 0;
  localparam int BC_PROP_LSB = 4;
  localparam int BC_PS1_LSB = 8;
  localparam int BC_PS2_LSB = 12;
  localparam int BC_SJW_LSB = 16;
  localparam int CT_TWO_SLOT = 0;
  localparam int CT_FORCE_RET = 1;
  localparam int CT_TS_CLR = 2;
  localparam int CT_TS_DIV_LSB = 3;
  localparam int CT_LISTEN = 5;
  localparam int SC_RX_EN = 0;
  localparam int SC_REMOTE_SEL = 1;
  localparam int SC_NEW_DATA = 3;

  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [31:0] BIT_CFG_RST = 32'h0000_3330;
  localparam logic [ID_W-1:0] MASK_RST = 29'h1FFF_FFFF;

  localparam int TQ_BASE_DIV = 2;
  localparam logic [2:0] CLK_SEL_MAX = 3'h4;
  localparam logic [3:0] RECESSIVE_RUN = 4'hB;
  localparam int BUSOFF_RUNS = 128;
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  localparam logic [8:0] TX_BUSOFF_LIMIT = 9'h100;

  typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PS1, SEG_PS2} ctf_seg_e;
endpackage

// ---- core/ctf_bit_timing.sv ----
`timescale 1ns/1ps
module ctf_bit_timing (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] clk_sel,
  input wire logic [3:0] prescale,
  input wire logic [2:0] prop_len,
  input wire logic [2:0] ps1_len,
  input wire logic [2:0] ps2_len,
  input wire logic [1:0] resync_jump_width,
  input wire logic rx_in,
  output logic sample_pulse,
  output logic sample_bit,
  output logic bit_start
);
  import ctf_pkg::*;

  logic [2:0] sel_eff;
  logic [9:0] tq_div;
  logic [9:0] pre_cnt_q;
  logic tq_tick;
  logic [4:0] prop_n, ps1_n, ps2_n, sjw_n, late_err, late_lim, ps1_end, ps2_end, ps2_left;
  logic rx_s1_q, rx_s2_q, rx_prev_q, edge_pend_q, synced_q, resync;
  logic [4:0] cnt_q, ext_q, cut_q;
  ctf_seg_e seg_q;

  always_comb begin
    sel_eff = (clk_sel > CLK_SEL_MAX) ? CLK_SEL_MAX : clk_sel;
    tq_div = 10'(TQ_BASE_DIV * (1 << sel_eff) * (32'(prescale) + 1)); // [R4] [R5] [R6]
    prop_n = {2'h0, prop_len} + 5'h01;
    ps1_n = {2'h0, ps1_len} + 5'h01;
    ps2_n = {2'h0, ps2_len} + 5'h01;
    sjw_n = {3'h0, resync_jump_width} + 5'h01;
    resync = edge_pend_q && !synced_q;
    late_err = (seg_q == SEG_PROP) ? cnt_q + 5'h01 : prop_n + cnt_q + 5'h01;
    late_lim = (late_err < sjw_n) ? late_err : sjw_n;
    ps1_end = ps1_n + ((resync && seg_q != SEG_SYNC) ? late_lim : ext_q) - 5'h01;
    ps2_left = ps2_n - cnt_q;
    ps2_end = ps2_n - cut_q - 5'h01;
  end

  assign tq_tick = (pre_cnt_q >= tq_div - 10'h001);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_q <= 10'h000;
    end else begin
      pre_cnt_q <= tq_tick ? 10'h000 : pre_cnt_q + 10'h001;
    end
  end

  // The first stage feeds only the second; edges are seen on the second stage.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
      edge_pend_q <= 1'b0;
    end else begin
      rx_s1_q <= rx_in;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
      if (rx_prev_q && !rx_s2_q) begin
        edge_pend_q <= 1'b1;
      end else if (tq_tick) begin
        edge_pend_q <= 1'b0;
      end
    end
  end

  // Only one resynchronisation per bit; an edge inside the sync quantum needs none.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      seg_q <= SEG_SYNC;
      cnt_q <= 5'h00;
      ext_q <= 5'h00;
      cut_q <= 5'h00;
      synced_q <= 1'b0;
      sample_pulse <= 1'b0;
      sample_bit <= 1'b1;
      bit_start <= 1'b0;
    end else begin
      sample_pulse <= 1'b0;
      bit_start <= 1'b0;
      if (tq_tick) begin
        case (seg_q)
          SEG_SYNC: begin // [R1]
            seg_q <= SEG_PROP;
            cnt_q <= 5'h00;
            ext_q <= 5'h00;
            cut_q <= 5'h00;
            synced_q <= 1'b0;
          end
          SEG_PROP, SEG_PS1: begin
            if (resync) begin
              ext_q <= late_lim; // [R2]
              synced_q <= 1'b1;
            end
            if (seg_q == SEG_PROP && cnt_q >= prop_n - 5'h01) begin
              seg_q <= SEG_PS1;
              cnt_q <= 5'h00;
            end else if (seg_q == SEG_PS1 && cnt_q >= ps1_end) begin
              seg_q <= SEG_PS2;
              cnt_q <= 5'h00;
              sample_pulse <= 1'b1; // [R26]
              sample_bit <= rx_s2_q;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          SEG_PS2: begin
            if (resync && ps2_left <= sjw_n) begin
              seg_q <= SEG_PROP; // [R3]
              cnt_q <= 5'h00;
              ext_q <= 5'h00;
              cut_q <= 5'h00;
              synced_q <= 1'b0;
              bit_start <= 1'b1;
            end else if (resync) begin
              cut_q <= sjw_n; // [R3]
              synced_q <= 1'b1;
              cnt_q <= cnt_q + 5'h01;
            end else if (cnt_q >= ps2_end) begin
              seg_q <= SEG_SYNC;
              cnt_q <= 5'h00;
              bit_start <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
          default: seg_q <= SEG_SYNC;
        endcase
      end
    end
  end
endmodule // ctf_bit_timing

// ---- tb/ctf_bus_node.sv ----
`timescale 1ns/1ps
// Other nodes share a wired-AND bus, so any dominant driver wins and the idle line is recessive.
module ctf_bus_node (
  input wire logic can_tx,
  input wire logic peer_dom,
  output logic can_rx
);
  assign can_rx = can_tx & ~peer_dom;
endmodule // ctf_bus_node

// ---- tb/can_timing_filter_timestamp_bench.sv ----
`timescale 1ns/1ps
module can_timing_filter_timestamp_bench;
  import ctf_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, can_rx, can_tx, pe_tx_bit, peer_dom;
  logic rx_frame_done, rx_frame_remote, err_tx_inc, store_valid, store_remote, comm_ready, busoff_flag;
  logic rx_frame_ext;
  logic [TS_W-1:0] store_ts;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [ID_W-1:0] rx_frame_id;
  logic [3:0] store_slot;
  int error_cnt, checked, cyc;
  ctf_top u_ctf_top (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .can_rx(can_rx), .can_tx(can_tx), .pe_tx_bit(pe_tx_bit),
    .rx_frame_done(rx_frame_done), .rx_frame_id(rx_frame_id), .rx_frame_ext(rx_frame_ext),
    .rx_frame_remote(rx_frame_remote), .err_rx_inc(1'b0), .err_tx_inc(err_tx_inc), .err_dec(1'b0),
    .store_valid(store_valid), .store_slot(store_slot), .store_remote(store_remote), .store_ts(store_ts),
    .comm_ready(comm_ready), .busoff_flag(busoff_flag));
  ctf_bus_node u_ctf_bus_node (.can_tx(can_tx), .peer_dom(peer_dom), .can_rx(can_rx));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A run far past the longest stamp measurement means a hung wait.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (comm_ready !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    chk({31'h0, comm_ready}, 32'h1);
  endtask
  task automatic frm(input logic [28:0] id, input logic rem, input logic [3:0] slot);
    rx_frame_done <= 1'b1; rx_frame_id <= id; rx_frame_remote <= rem;
    @(posedge mclk);
    rx_frame_done <= 1'b0;
    #1;
    chk({26'h0, store_valid, store_remote, store_slot}, {26'h0, 1'b1, rem, slot});
    @(posedge mclk);
  endtask
  // Clears the stamp, then expects nine to eleven ticks after ten reference periods of t cycles.
  task automatic tsc(input int t, input logic [1:0] div);
    xf(1'b1, OFF_CTRL, {27'h0, div, 3'h4});
    // Read data is fetched at the address phase, so the clear needs one idle cycle to land first.
    @(posedge mclk);
    xf(1'b0, OFF_TS_VALUE, 32'h0);
    chk({31'h0, r < 32'h2}, 32'h1);
    repeat (t * 10) @(posedge mclk);
    xf(1'b0, OFF_TS_VALUE, 32'h0);
    chk({31'h0, r >= 32'h9 && r <= 32'hB}, 32'h1);
  endtask
  initial begin
    hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hwdata = 32'h0; pe_tx_bit = 1'b1;
    peer_dom = 1'b1; rx_frame_done = 1'b0; rx_frame_id = '0; rx_frame_remote = 1'b0; err_tx_inc = 1'b0;
    rx_frame_ext = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rc(OFF_CLK_SEL, {29'h0, CLK_SEL_RST});
    rc(OFF_BIT_CFG, BIT_CFG_RST);
    rc(OFF_GMASK, {3'h0, MASK_RST});
    rc(8'hFC, 32'h0);
    repeat (100) @(posedge mclk);
    chk({31'h0, comm_ready}, 32'h0);
    peer_dom <= 1'b0;
    wait_ready;
    xf(1'b1, 8'h40, 32'h123);
    xf(1'b1, 8'h44, 32'h123);
    xf(1'b1, 8'h80, 32'h1);
    xf(1'b1, 8'h84, 32'h1);
    frm(29'h123, 1'b0, 4'h0);
    xf(1'b1, OFF_GMASK, 32'h7F0);
    frm(29'h12A, 1'b0, 4'h0);
    rc(OFF_FILT_SUP, 32'h2504);
    // Two extended slots differ only above bit 10, so the lower one wins if only 11 bits are compared.
    xf(1'b1, OFF_GMASK, 32'h1FFF_FFFF);
    xf(1'b1, OFF_ID_FMT, 32'hC);
    xf(1'b1, 8'h48, 32'h0ABC123);
    xf(1'b1, 8'h4C, 32'h1ABC123);
    xf(1'b1, 8'h88, 32'h1);
    xf(1'b1, 8'h8C, 32'h1);
    rx_frame_ext <= 1'b1;
    frm(29'h1ABC123, 1'b0, 4'h3);
    frm(29'h0ABC123, 1'b0, 4'h2);
    rx_frame_ext <= 1'b0;
    // Mode change done before the pair is armed, the pair shares one identifier and mask.
    xf(1'b1, OFF_CTRL, 32'h1);
    xf(1'b1, OFF_LMASK_A, 32'h0);
    xf(1'b1, OFF_LMASK_B, 32'h0);
    xf(1'b1, 8'hB8, 32'h1);
    xf(1'b1, 8'hBC, 32'h1);
    frm(29'h300, 1'b0, 4'hE);
    frm(29'h123, 1'b0, 4'h0);
    frm(29'h301, 1'b1, 4'hF);
    frm(29'h302, 1'b0, 4'hE);
    for (int s = 0; s < 5; s++) begin
      xf(1'b1, OFF_CLK_SEL, s);
      xf(1'b1, OFF_BIT_CFG, 32'h3330 | s);
      tsc(26 * (1 << s) * (s + 1), 2'h0);
    end
    xf(1'b1, OFF_CLK_SEL, 32'h0);
    xf(1'b1, OFF_BIT_CFG, BIT_CFG_RST);
    for (int d = 1; d < 4; d++) tsc(26 << d, d[1:0]);
    // With the slowest stamp rate a frame right after a clear must capture zero.
    xf(1'b1, OFF_CTRL, 32'h1C);
    @(posedge mclk);
    frm(29'h123, 1'b0, 4'h0);
    chk({16'h0, store_ts}, 32'h0);
    rc(8'hC0, 32'h0);
    err_tx_inc <= 1'b1;
    repeat (32) @(posedge mclk);
    err_tx_inc <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, busoff_flag}, 32'h1);
    xf(1'b1, OFF_CTRL, 32'h2);
    repeat (2) @(posedge mclk);
    chk({30'h0, busoff_flag, comm_ready}, 32'h0);
    rc(OFF_ERR_CNT, 32'h0);
    rc(OFF_BIT_CFG, BIT_CFG_RST);
    xf(1'b0, OFF_CTRL, 32'h0);
    chk({31'h0, r[CT_FORCE_RET]}, 32'h0);
    repeat (200) @(posedge mclk);
    chk({31'h0, comm_ready}, 32'h0);
    wait_ready;
    // No transmit is requested once listening, only the raw drive level is forced low.
    pe_tx_bit <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, can_tx}, 32'h0);
    xf(1'b1, OFF_CTRL, 32'h20);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, can_tx}, 32'h1);
    end_sim;
  end
endmodule // can_timing_filter_timestamp_bench
